//--- rtl/pswc_clkgate.v
`timescale 1ns/1ps
`include "pswc_consts.vh"

// internal clock connection and bus clock stop permission
module pswc_clkgate (
    input  wire clk,
    input  wire rstn,
    input  wire sleep_bit,
    input  wire snooze_bit,
    input  wire hw_reset,
    input  wire need_clk,
    input  wire event_done,
    output reg  core_clk_en_q,
    output reg  clk_stop_ok_q
);

    localparam [1:0] CG_RUN     = 2'h0;
    localparam [1:0] CG_SLEEP   = 2'h1;
    localparam [1:0] CG_SNZ_OFF = 2'h2;
    localparam [1:0] CG_SNZ_ON  = 2'h3;

    reg [1:0] state_q;
    reg [1:0] state_d;

    // sleep outranks snooze should software set both
    always @* begin
        state_d = state_q;
        case (state_q)
            CG_RUN: begin
                if (sleep_bit && !hw_reset) begin
                    state_d = CG_SLEEP;
                end else if (snooze_bit && !hw_reset) begin
                    state_d = need_clk ? CG_SNZ_ON : CG_SNZ_OFF;
                end
            end
            CG_SLEEP: begin
                if (hw_reset || !sleep_bit) begin
                    state_d = CG_RUN;
                end
            end
            CG_SNZ_OFF: begin
                if (hw_reset || sleep_bit || !snooze_bit) begin
                    state_d = CG_RUN;
                end else if (need_clk) begin
                    state_d = CG_SNZ_ON;
                end
            end
            default: begin
                if (hw_reset || sleep_bit || !snooze_bit) begin
                    state_d = CG_RUN;
                end else if (event_done && !need_clk) begin
                    state_d = CG_SNZ_OFF;
                end
            end
        endcase
    end

    // outputs follow the next state so they never lag the state register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= CG_RUN;
            core_clk_en_q <= 1'b1;
            clk_stop_ok_q <= 1'b0;
        end else begin
            state_q       <= state_d;
            core_clk_en_q <= (state_d == CG_RUN) || (state_d == CG_SNZ_ON);
            clk_stop_ok_q <= (state_d == CG_SLEEP) || (state_d == CG_SNZ_OFF);
        end
    end

endmodule // pswc_clkgate

//--- rtl/pswc_consts.vh
`ifndef PSWC_CONSTS_VH
`define PSWC_CONSTS_VH

// configuration-space offsets of the two registers
`define PSWC_CLKSAVE_OFS      8'h40
`define PSWC_PWRCTL_OFS       8'hE0

// clock_saving_and_driver_area fields
`define PSWC_SLEEP_BIT        31
`define PSWC_SNOOZE_BIT       30
`define PSWC_SCRATCH_MSB      15
`define PSWC_SCRATCH_LSB      8

// power_state_control_status fields
`define PSWC_WFLAG_BIT        15
`define PSWC_WEN_BIT          8
`define PSWC_PSTATE_MSB       1
`define PSWC_PSTATE_LSB       0

// reset values
`define PSWC_SLEEP_RST        1'b1
`define PSWC_SNOOZE_RST       1'b0
`define PSWC_SCRATCH_RST      8'h00
`define PSWC_PSTATE_RST       2'h0
`define PSWC_WFLAG_RST        1'b0
`define PSWC_WEN_RST          1'b0

// power state encodings
`define PSWC_PS_D0            2'h0
`define PSWC_PS_D1            2'h1
`define PSWC_PS_D2            2'h2
`define PSWC_PS_D3HOT         2'h3

`endif

//--- rtl/pswc_top.v
`timescale 1ns/1ps
`include "pswc_consts.vh"

// Notes on behaviour
// - event sets flag; pin follows if enabled
// - flag cleared by power-up or write one
// - flag clear drops the wake pin
// - general enable clear also clears flag
// - enable clear keeps wake pin low
// - enable cleared only by write or power-up reset
// - two-bit power state written and read back
// - power state is D0 after power-up
// - sleep disconnects most internal clocks
// - sleep allows configuration accesses only
// - sleep allows bus clock stop via clkrun
// - hardware reset temporarily leaves sleep mode
// - clearing sleep bit restores clocks permanently
// - snooze gates clocks while not needed
// - snooze reconnects clocks until event completes
// - snooze allows clock stop when unneeded
// - clearing snooze keeps clocks connected
// - eight-bit scratch field, free read write
// - hardware reset: sleep one, snooze zero

module pswc_top (
    input  wire        clk,
    input  wire        rstn,
    input  wire        hw_reset,
    input  wire        cfg_sel,
    input  wire        cfg_we,
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_ack,
    input  wire        pm_event,
    input  wire        general_enable,
    input  wire        need_clk,
    input  wire        event_done,
    output wire        wake_req,
    output wire        core_clk_en,
    output wire        clk_stop_ok,
    output reg         mem_io_access_en,
    output wire [1:0]  power_state
);

    // register fields held here
    reg        sleep_q;
    reg        sleep_d;
    reg        snooze_q;
    reg        snooze_d;
    reg [7:0]  scratch_q;
    reg [7:0]  scratch_d;
    reg [1:0]  pstate_q;
    reg [1:0]  pstate_d;

    // decoded access strobes
    wire       hit_clksave;
    wire       hit_pwrctl;
    wire       wr_clksave;
    wire       wr_pwrctl;
    wire       wr_en_lane;
    wire       flag_w1c;

    // state returned from the submodules
    wire       wflag;
    wire       wen;
    wire       clk_en_w;
    wire       stop_ok_w;

    // read word assembled before it is registered
    reg [31:0] rdata_d;

    // address compare, used for both registers; low two bits are not compared
    function addr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addr_hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    // take a new byte only where its lane is enabled
    function [7:0] lane_merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input       lane_en;
        begin
            if (lane_en) begin
                lane_merge = new_val;
            end else begin
                lane_merge = old_val;
            end
        end
    endfunction

    // configuration accesses are always decoded, even in sleep mode
    // config path stays open
    assign hit_clksave = addr_hit(cfg_addr, `PSWC_CLKSAVE_OFS);
    assign hit_pwrctl  = addr_hit(cfg_addr, `PSWC_PWRCTL_OFS);
    assign wr_clksave  = cfg_sel & cfg_we & hit_clksave;
    assign wr_pwrctl   = cfg_sel & cfg_we & hit_pwrctl;

    // wake controls live in the second byte of the power register
    assign wr_en_lane  = wr_pwrctl & cfg_be[1];
    assign flag_w1c    = wr_en_lane & cfg_wdata[`PSWC_WFLAG_BIT];

    // clock saving register next values
    always @* begin
        sleep_d   = sleep_q;
        snooze_d  = snooze_q;
        scratch_d = scratch_q;
        if (wr_clksave) begin
            scratch_d = lane_merge(scratch_q, cfg_wdata[`PSWC_SCRATCH_MSB:`PSWC_SCRATCH_LSB], cfg_be[1]);
            if (cfg_be[3]) begin
                sleep_d  = cfg_wdata[`PSWC_SLEEP_BIT];
                snooze_d = cfg_wdata[`PSWC_SNOOZE_BIT];
            end
        end
        // hardware reset wins over a write in the same cycle
        // hardware reset values
        if (hw_reset) begin
            sleep_d  = `PSWC_SLEEP_RST;
            snooze_d = `PSWC_SNOOZE_RST;
        end
    end

    // power state next value
    always @* begin
        pstate_d = pstate_q;
        if (wr_pwrctl && cfg_be[0]) begin
            pstate_d = cfg_wdata[`PSWC_PSTATE_MSB:`PSWC_PSTATE_LSB];
        end
        // hardware reset returns the function to full power
        if (hw_reset) begin
            pstate_d = `PSWC_PS_D0;
        end
    end

    // scratch keeps its value over a hardware reset; only power-up clears it
    // power-up to D0
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_q   <= `PSWC_SLEEP_RST;
            snooze_q  <= `PSWC_SNOOZE_RST;
            scratch_q <= `PSWC_SCRATCH_RST;
            pstate_q  <= `PSWC_PS_D0;
        end else begin
            sleep_q   <= sleep_d;
            snooze_q  <= snooze_d;
            scratch_q <= scratch_d;
            pstate_q  <= pstate_d;
        end
    end

    // wake flag, enable and pin
    pswc_wake u_wake (
        .clk                  (clk),
        .rstn                 (rstn),
        .pm_event             (pm_event),
        .general_enable       (general_enable),
        .en_wr                (wr_en_lane),
        .en_wdata             (cfg_wdata[`PSWC_WEN_BIT]),
        .flag_w1c             (flag_w1c),
        .wake_event_flag_q    (wflag),
        .wake_output_enable_q (wen),
        .wake_req_q           (wake_req)
    );

    // clock connection control fed by the mode bits
    pswc_clkgate u_clkgate (
        .clk           (clk),
        .rstn          (rstn),
        .sleep_bit     (sleep_q),
        .snooze_bit    (snooze_q),
        .hw_reset      (hw_reset),
        .need_clk      (need_clk),
        .event_done    (event_done),
        .core_clk_en_q (clk_en_w),
        .clk_stop_ok_q (stop_ok_w)
    );

    assign core_clk_en = clk_en_w;
    assign clk_stop_ok = stop_ok_w;
    assign power_state = pstate_q;

    // read word; unmapped offsets and reserved bits read zero
    always @* begin
        rdata_d = 32'h00000000;
        if (hit_clksave) begin
            rdata_d[`PSWC_SLEEP_BIT]                      = sleep_q;
            rdata_d[`PSWC_SNOOZE_BIT]                     = snooze_q;
            rdata_d[`PSWC_SCRATCH_MSB:`PSWC_SCRATCH_LSB] = scratch_q;
        end else if (hit_pwrctl) begin
            rdata_d[`PSWC_WFLAG_BIT]                    = wflag;
            rdata_d[`PSWC_WEN_BIT]                      = wen;
            rdata_d[`PSWC_PSTATE_MSB:`PSWC_PSTATE_LSB] = pstate_q;
        end
    end

    // one access per request; answer one edge later with data held till next
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h00000000;
        end else begin
            cfg_ack <= cfg_sel;
            if (cfg_sel && !cfg_we) begin
                cfg_rdata <= rdata_d;
            end
        end
    end

    // memory and io paths close while sleep is in force; a held hardware
    // reset reopens them since the device leaves sleep for that time
    // gate other paths
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_io_access_en <= 1'b0;
        end else begin
            mem_io_access_en <= ~sleep_d | hw_reset;
        end
    end

endmodule // pswc_top

//--- rtl/pswc_wake.v
`timescale 1ns/1ps
`include "pswc_consts.vh"

// wake event flag, wake output enable and the wake request pin
module pswc_wake (
    input  wire clk,
    input  wire rstn,
    input  wire pm_event,
    input  wire general_enable,
    input  wire en_wr,
    input  wire en_wdata,
    input  wire flag_w1c,
    output reg  wake_event_flag_q,
    output reg  wake_output_enable_q,
    output reg  wake_req_q
);

    reg  ge_prev_q;
    wire ge_fall;
    reg  flag_d;
    reg  en_d;

    // general enable dropping is seen as a one-cycle clear
    assign ge_fall = ge_prev_q & ~general_enable;

    // next state: the event set wins over every clear in the same cycle
    always @* begin
        flag_d = wake_event_flag_q;
        if (ge_fall) begin
            flag_d = 1'b0;
        end
        if (flag_w1c) begin
            flag_d = 1'b0;
        end
        if (pm_event) begin
            flag_d = 1'b1;
        end
        en_d = wake_output_enable_q;
        if (en_wr) begin
            en_d = en_wdata;
        end
    end

    // only the power-up reset clears these; hardware reset is not seen here
    // enable power-up only
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ge_prev_q            <= 1'b0;
            wake_event_flag_q    <= `PSWC_WFLAG_RST;
            wake_output_enable_q <= `PSWC_WEN_RST;
            wake_req_q           <= 1'b0;
        end else begin
            ge_prev_q            <= general_enable;
            wake_event_flag_q    <= flag_d;
            wake_output_enable_q <= en_d;
            wake_req_q           <= flag_d & en_d;
        end
    end

endmodule // pswc_wake

//--- verif/pswc_host.sv
`timescale 1ns/1ps
// configuration software model: one access per call
module pswc_host (
    input  wire logic        clk,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata,
    output logic             cfg_sel,
    output logic             cfg_we,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata
);
    initial begin
        cfg_sel = 1'b0;
        cfg_we = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
    end
    // select is a one-cycle pulse; answer is sampled the cycle after
    task automatic acc(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
        if (we && a == 8'h40 && be[3]) d[30] = d[30] & ~d[31];
        @(negedge clk);
        cfg_sel = 1'b1;
        cfg_we = we;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_sel = 1'b0;
        ok = (cfg_ack === 1'b1);
        q = cfg_rdata;
        // released lines must not look like a held value
        cfg_addr = ~a;
        cfg_wdata = ~d;
    endtask
endmodule // pswc_host

//--- verif/pswc_props.sv
`timescale 1ns/1ps
// port-level checks on the power and wake block
module pswc_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        hw_reset,
    input wire logic        cfg_sel,
    input wire logic        cfg_we,
    input wire logic [7:0]  cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic        cfg_ack,
    input wire logic        pm_event,
    input wire logic        general_enable,
    input wire logic        need_clk,
    input wire logic        wake_req,
    input wire logic        core_clk_en,
    input wire logic        clk_stop_ok,
    input wire logic        mem_io_access_en,
    input wire logic [1:0]  power_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // write strobe decoded per register
    wire wr40 = cfg_sel && cfg_we && cfg_addr == 8'h40 && !hw_reset;
    wire wre0 = cfg_sel && cfg_we && cfg_addr == 8'hE0 && !hw_reset;

    AST_ACK: assert property (1'b1 |=> cfg_ack == $past(cfg_sel))
        else $error("ack not one cycle after select");
    AST_PSWR: assert property (wre0 && cfg_be[0] |=> power_state == $past(cfg_wdata[1:0]))
        else $error("power state not written");
    AST_WAKE_RISE: assert property ($rose(wake_req) |-> $past(pm_event || (cfg_sel && cfg_we)))
        else $error("wake pin rose without cause");
    AST_W1C: assert property (wre0 && cfg_be[1] && cfg_wdata[15] && !pm_event |=> !wake_req)
        else $error("wake pin kept after flag clear");
    AST_GEN_CLR: assert property ($fell(general_enable) && !pm_event |=> !wake_req)
        else $error("general enable fall kept wake pin");
    AST_HWRST: assert property (hw_reset |=> core_clk_en && mem_io_access_en && power_state == 2'h0)
        else $error("hardware reset did not leave sleep");
    AST_CLKREL: assert property (clk_stop_ok != core_clk_en)
        else $error("clock stop permission and clocks disagree");
    AST_NEED: assert property (mem_io_access_en && need_clk && !cfg_sel && !hw_reset |=> core_clk_en)
        else $error("clocks not reconnected on need");
    AST_SLEEP: assert property (wr40 && cfg_be[3] && cfg_wdata[31] |=> !mem_io_access_en ##1 !core_clk_en)
        else $error("sleep write did not gate");

    COV_WRITE: cover property (wre0 ##1 cfg_ack);
    COV_WAKE: cover property (pm_event ##1 wake_req);
    COV_HWRST: cover property (hw_reset ##1 core_clk_en);
endmodule // pswc_props

bind pswc_top pswc_props i_pswc_props (.clk(clk), .rstn(rstn), .hw_reset(hw_reset), .cfg_sel(cfg_sel),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
    .pm_event(pm_event), .general_enable(general_enable), .need_clk(need_clk), .wake_req(wake_req),
    .core_clk_en(core_clk_en), .clk_stop_ok(clk_stop_ok), .mem_io_access_en(mem_io_access_en),
    .power_state(power_state));

//--- verif/pswc_top_tb.sv
`timescale 1ns/1ps
module pswc_top_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hw_reset = 1'b0;
    logic        pm_event = 1'b0;
    logic        general_enable = 1'b1;
    logic        need_clk = 1'b0;
    logic        event_done = 1'b0;
    logic        cfg_sel, cfg_we, cfg_ack, wake_req, core_clk_en, clk_stop_ok, mem_io_access_en;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [1:0]  power_state;
    int          err_total = 0;
    int          comparisons = 0;

    always #20 clk = ~clk;

    pswc_host i_pswc_host (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_sel(cfg_sel),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    pswc_top i_pswc_top (.clk(clk), .rstn(rstn), .hw_reset(hw_reset), .cfg_sel(cfg_sel), .cfg_we(cfg_we),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
        .pm_event(pm_event), .general_enable(general_enable), .need_clk(need_clk), .event_done(event_done),
        .wake_req(wake_req), .core_clk_en(core_clk_en), .clk_stop_ok(clk_stop_ok),
        .mem_io_access_en(mem_io_access_en), .power_state(power_state));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        i_pswc_host.acc(1'b1, a, be, d, q, ok);
        chk(ok, 1);
    endtask
    // read with a mask so undefined bits are not judged
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        logic        ok;
        i_pswc_host.acc(1'b0, a, 4'hF, 32'h0, q, ok);
        chk(ok, 1);
        chk(q & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic t_reset;
        rdc(8'h40, 32'hC0000000, 32'h80000000);
        rdc(8'hE0, 32'hFFFFFFFF, 32'h0);
        chk({core_clk_en, clk_stop_ok, mem_io_access_en}, 3'b010);
        $display("reset values done");
    endtask
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            wr(8'hE0, 4'h1, i);
            rdc(8'hE0, 32'h3, i);
            chk(power_state, i);
        end
        wr(8'h40, 4'h2, 32'h0000A500);
        rdc(8'h40, 32'hC000FF00, 32'h8000A500);
        rdc(8'h80, 32'hFFFFFFFF, 32'h0);
        $display("register access done");
    endtask
    task automatic t_clocks;
        wr(8'h40, 4'h8, 32'h0);
        cyc(1);
        chk({core_clk_en, clk_stop_ok, mem_io_access_en}, 3'b101);
        wr(8'h40, 4'h8, 32'h40000000);
        cyc(1);
        chk({core_clk_en, clk_stop_ok}, 2'b01);
        need_clk = 1'b1;
        cyc(1);
        chk({core_clk_en, clk_stop_ok}, 2'b10);
        need_clk = 1'b0;
        cyc(1);
        chk(core_clk_en, 1);
        event_done = 1'b1;
        cyc(1);
        event_done = 1'b0;
        cyc(1);
        chk(core_clk_en, 0);
        wr(8'h40, 4'h8, 32'h0);
        cyc(1);
        chk(core_clk_en, 1);
        wr(8'h40, 4'h8, 32'h80000000);
        chk(mem_io_access_en, 0);
        cyc(1);
        chk({core_clk_en, clk_stop_ok}, 2'b01);
        $display("clock saving done");
    endtask
    task automatic t_wake;
        wr(8'hE0, 4'h2, 32'h00000100);
        pm_event = 1'b1;
        cyc(1);
        pm_event = 1'b0;
        chk(wake_req, 1);
        wr(8'hE0, 4'h2, 32'h00000100);
        chk(wake_req, 1);
        wr(8'hE0, 4'h2, 32'h00008100);
        chk(wake_req, 0);
        pm_event = 1'b1;
        cyc(1);
        pm_event = 1'b0;
        chk(wake_req, 1);
        general_enable = 1'b0;
        cyc(1);
        general_enable = 1'b1;
        chk(wake_req, 0);
        wr(8'hE0, 4'h2, 32'h0);
        pm_event = 1'b1;
        cyc(1);
        pm_event = 1'b0;
        chk(wake_req, 0);
        wr(8'hE0, 4'h2, 32'h00000100);
        chk(wake_req, 1);
        hw_reset = 1'b1;
        cyc(2);
        chk({core_clk_en, mem_io_access_en}, 2'b11);
        hw_reset = 1'b0;
        cyc(2);
        chk({core_clk_en, mem_io_access_en}, 2'b00);
        rdc(8'hE0, 32'h00008103, 32'h00008100);
        rdc(8'h40, 32'hC000FF00, 32'h8000A500);
        $display("wake control done");
    endtask
    task automatic t_powerup;
        rstn = 1'b0;
        cyc(2);
        chk({wake_req, power_state}, 3'b000);
        rstn = 1'b1;
        rdc(8'hE0, 32'hFFFFFFFF, 32'h0);
        chk(wake_req, 0);
        $display("power-up reset done");
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard well beyond the sequence length
    initial begin
        #2000000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        cyc(6);
        rstn = 1'b1;
        t_reset;
        t_regs;
        t_clocks;
        t_wake;
        t_powerup;
        tally_and_finish;
    end
endmodule // pswc_top_tb
